// >>> alic_top.sv
/*
 * Analogue input limit checker: APB register file, sample store,
 * data formatting, sticky error status and interrupt.
 * Assumes an APB master on pclk and samples synchronous to pclk.
 */
`timescale 1ns/10ps

// Notes on behaviour
// - Supply short raises error when enabled
// - Data format offset, sign-magnitude, two's
// - Flag over/under range beyond half percent
// - Upper user limit error when enabled
// - Lower user limit error when enabled
// - Limit MSB set means negative magnitude
module alic_top (
    input wire logic pclk, // Bus clock, 20 MHz
    input wire logic presetn, // Async reset, low active
    input wire logic ce, // Clock enable, freezes state
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped
    input wire logic sample_valid, // New sample set
    input wire logic [63:0] sample_data, // Four signed samples
    input wire logic supply_short, // Sensor supply short level
    output logic irq // Interrupt level
);
    localparam int NCH = alic_pkg::NCH;
    localparam int VW = alic_pkg::VW;
    localparam int RW = alic_pkg::RW;
    localparam int STW = alic_pkg::STW;

    logic [5:0] ctrl;
    logic [11:0] rng;
    logic [7:0] limen;
    logic [11:0] status;
    logic [11:0] irqen;
    logic [15:0] up_lim [NCH];
    logic [15:0] lo_lim [NCH];
    logic [15:0] smp [NCH];

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    function automatic logic reg_hit(input logic [7:0] a,
                                     input logic [7:0] base,
                                     input logic [7:0] mask);
        return (a & ~mask) == base;
    endfunction : reg_hit

    logic acc_phase;
    logic wr_en;
    logic [1:0] ch;
    logic hit_ctrl;
    logic hit_range;
    logic hit_limen;
    logic hit_status;
    logic hit_clear;
    logic hit_irqen;
    logic hit_up;
    logic hit_lo;
    logic hit_data;
    logic hit_any;
    logic [1:0] fmt;
    logic [15:0] raw_sel;
    logic [31:0] rd_word;

    // Answer one cycle into the access phase
    assign acc_phase = psel && penable && !pready;
    // Writes land only at the edge where pready is sampled high
    assign wr_en = psel && penable && pready && pwrite;
    assign ch = paddr[3:2];
    assign hit_ctrl = reg_hit(paddr, alic_pkg::OFF_CTRL, 8'h00);
    assign hit_range = reg_hit(paddr, alic_pkg::OFF_RANGE, 8'h00);
    assign hit_limen = reg_hit(paddr, alic_pkg::OFF_LIMEN, 8'h00);
    assign hit_status = reg_hit(paddr, alic_pkg::OFF_STATUS, 8'h00);
    assign hit_clear = reg_hit(paddr, alic_pkg::OFF_CLEAR, 8'h00);
    assign hit_irqen = reg_hit(paddr, alic_pkg::OFF_IRQEN, 8'h00);
    assign hit_up = reg_hit(paddr, alic_pkg::OFF_UPLIM, alic_pkg::ARR_MASK);
    assign hit_lo = reg_hit(paddr, alic_pkg::OFF_LOLIM, alic_pkg::ARR_MASK);
    assign hit_data = reg_hit(paddr, alic_pkg::OFF_DATA, alic_pkg::ARR_MASK);
    assign hit_any = hit_ctrl || hit_range || hit_limen || hit_status ||
                     hit_clear || hit_irqen || hit_up || hit_lo || hit_data;
    assign fmt = ctrl[alic_pkg::CTRL_FMT_LSB +: 2];
    assign raw_sel = smp[ch];

    // ----------------------------------------------------------------
    // Read selection
    // ----------------------------------------------------------------
    // Clear register is write-only and reads as zero
    assign rd_word = hit_ctrl ? 32'(ctrl) :
                     hit_range ? 32'(rng) :
                     hit_limen ? 32'(limen) :
                     hit_status ? 32'(status) :
                     hit_irqen ? 32'(irqen) :
                     hit_up ? 32'(up_lim[ch]) :
                     hit_lo ? 32'(lo_lim[ch]) :
                     hit_data ? 32'(alic_pkg::alic_format(raw_sel, fmt)) :
                     32'h0000_0000;

    // Bus answer, fixed one wait state
    // Data and error latch together with pready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready <= acc_phase;
            if (acc_phase) begin
                prdata <= rd_word;
                pslverr <= !hit_any;
            end
        end
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    // Unit-wide enables default on, user limit checks default off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= alic_pkg::CTRL_RST;
            rng <= alic_pkg::RANGE_RST;
            limen <= alic_pkg::LIMEN_RST;
            irqen <= alic_pkg::IRQEN_RST;
        end else if (ce && wr_en) begin
            if (hit_ctrl) ctrl <= pwdata[5:0];
            if (hit_range) rng <= pwdata[11:0];
            if (hit_limen) limen <= pwdata[7:0];
            if (hit_irqen) irqen <= pwdata[STW-1:0];
        end
    end

    // Limit codes stored as written; band applied at use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NCH; i++) begin
                up_lim[i] <= alic_pkg::LIM_RST;
                lo_lim[i] <= alic_pkg::LIM_RST;
            end
        end else if (ce && wr_en) begin
            if (hit_up) up_lim[ch] <= pwdata[15:0];
            if (hit_lo) lo_lim[ch] <= pwdata[15:0];
        end
    end

    // ----------------------------------------------------------------
    // Sample store and channel checks
    // ----------------------------------------------------------------
    // Raw copy kept; a format change applies at next read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NCH; i++) begin
                smp[i] <= 16'h0000;
            end
        end else if (ce && sample_valid) begin
            for (int i = 0; i < NCH; i++) begin
                smp[i] <= sample_data[i*VW +: VW];
            end
        end
    end

    logic [NCH-1:0] up_hit;
    logic [NCH-1:0] lo_hit;
    logic [NCH-1:0] ovr_hit;
    logic [NCH-1:0] udr_hit;

    // Checks look at the incoming sample, not the stored copy
    // so an error lands on the same edge as its sample
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : gen_chk
            alic_limit_chk u_chk (
                .rng(rng[g*RW +: RW]),
                .smp(sample_data[g*VW +: VW]),
                .up_code(up_lim[g]),
                .lo_code(lo_lim[g]),
                .up_hit(up_hit[g]),
                .lo_hit(lo_hit[g]),
                .ovr_hit(ovr_hit[g]),
                .udr_hit(udr_hit[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Events, sticky status and interrupt
    // ----------------------------------------------------------------
    logic [STW-1:0] ev;
    logic [STW-1:0] clr;
    logic [STW-1:0] next_status;
    logic irq_any;

    assign ev[alic_pkg::ST_SHORT] =
        ctrl[alic_pkg::CTRL_SHORT_EN] && supply_short;
    assign ev[alic_pkg::ST_OVR] =
        ctrl[alic_pkg::CTRL_OVR_EN] && sample_valid && (|ovr_hit);
    assign ev[alic_pkg::ST_UDR] =
        ctrl[alic_pkg::CTRL_UDR_EN] && sample_valid && (|udr_hit);
    assign ev[3] = 1'b0;
    assign ev[alic_pkg::ST_UP_LSB +: NCH] = sample_valid ?
        (up_hit & limen[alic_pkg::LIMEN_UP_LSB +: NCH]) : '0;
    assign ev[alic_pkg::ST_LO_LSB +: NCH] = sample_valid ?
        (lo_hit & limen[alic_pkg::LIMEN_LO_LSB +: NCH]) : '0;
    assign clr = (wr_en && hit_clear) ? pwdata[STW-1:0] : '0;
    // A new event beats a clear in the same cycle
    assign next_status = (status & ~clr) | ev;
    assign irq_any = |(status & irqen);

    // Interrupt trails status by one edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= alic_pkg::STATUS_RST;
            irq <= 1'b0;
        end else if (ce) begin
            status <= next_status;
            irq <= irq_any;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Each check looks one edge after its cause
    AST_BUS_READY: assert property (ce && acc_phase |=> pready)
        else $error("pready missing after access phase");

    AST_SHORT_SET: assert property (
        ce && supply_short && ctrl[alic_pkg::CTRL_SHORT_EN]
        |=> status[alic_pkg::ST_SHORT])
        else $error("supply short not flagged");
    AST_SHORT_CAUSE: assert property (
        $rose(status[alic_pkg::ST_SHORT])
        |-> $past(supply_short) && $past(ctrl[alic_pkg::CTRL_SHORT_EN]))
        else $error("short flag without enabled cause");

    AST_FMT_OFFSET: assert property (
        ce && acc_phase && hit_data && fmt == alic_pkg::FMT_OFFSET
        |=> prdata[15:0] == ($past(raw_sel) ^ alic_pkg::SIGN_BIT))
        else $error("offset binary read mismatch");

    AST_OVR_CAUSE: assert property (
        $rose(status[alic_pkg::ST_OVR])
        |-> $past(ctrl[alic_pkg::CTRL_OVR_EN]) && $past(sample_valid))
        else $error("over range flag without enabled cause");
    AST_OVR_SET: assert property (
        ce && ev[alic_pkg::ST_OVR] |=> status[alic_pkg::ST_OVR])
        else $error("over range event lost");
    AST_UDR_CAUSE: assert property (
        $rose(status[alic_pkg::ST_UDR])
        |-> $past(ctrl[alic_pkg::CTRL_UDR_EN]) && $past(|udr_hit))
        else $error("under range flag without cause");

    AST_UP_SET: assert property (
        ce && sample_valid && up_hit[0] && limen[alic_pkg::LIMEN_UP_LSB]
        |=> status[alic_pkg::ST_UP_LSB])
        else $error("upper limit error not flagged");
    AST_LO_SET: assert property (
        ce && sample_valid && lo_hit[0] && limen[alic_pkg::LIMEN_LO_LSB]
        |=> status[alic_pkg::ST_LO_LSB])
        else $error("lower limit error not flagged");
    AST_LO_CAUSE: assert property (
        $rose(status[alic_pkg::ST_LO_LSB])
        |-> $past(limen[alic_pkg::LIMEN_LO_LSB]))
        else $error("lower limit flag while disabled");

    // Unipolar bands clamp a negative limit up: bipolar only
    AST_NEG_LIMIT: assert property (
        ce && sample_valid && limen[alic_pkg::LIMEN_UP_LSB] &&
        rng[RW-1:0] <= 3'h2 &&
        up_lim[0][15] && !sample_data[15] && sample_data[15:0] != 16'h0000
        |=> status[alic_pkg::ST_UP_LSB])
        else $error("negative upper limit not honoured");

    AST_IRQ: assert property (ce |=> irq == $past(irq_any))
        else $error("irq does not follow enabled status");

    // Main scenarios
    COV_SHORT: cover property ($rose(status[alic_pkg::ST_SHORT]));
    COV_UP: cover property ($rose(status[alic_pkg::ST_UP_LSB]));
    COV_LO: cover property ($rose(status[alic_pkg::ST_LO_LSB]));
    COV_CLEAR: cover property (wr_en && hit_clear && ce);
    COV_IRQ: cover property ($rose(irq));

endmodule : alic_top

// >>> alic_pkg.sv
/*
 * Shared constants for the analogue input limit checker: register map,
 * field positions, reset values, range tables and value helpers.
 * Assumes samples arrive as signed 16-bit counts of hundredths of the
 * channel unit (V or mA).
 */
package alic_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int NCH = 4;
    localparam int VW = 16;
    localparam int RW = 3;
    localparam int STW = 12;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_RANGE = 8'h04;
    localparam logic [7:0] OFF_LIMEN = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_CLEAR = 8'h10;
    localparam logic [7:0] OFF_IRQEN = 8'h14;
    localparam logic [7:0] OFF_UPLIM = 8'h20;
    localparam logic [7:0] OFF_LOLIM = 8'h30;
    localparam logic [7:0] OFF_DATA = 8'h40;
    localparam logic [7:0] ARR_MASK = 8'h0C;

    // ----------------------------------------------------------------
    // Fields and reset values
    // ----------------------------------------------------------------
    localparam int CTRL_SHORT_EN = 0;
    localparam int CTRL_OVR_EN = 1;
    localparam int CTRL_UDR_EN = 2;
    localparam int CTRL_FMT_LSB = 4;
    localparam logic [5:0] CTRL_RST = 6'h07;
    localparam logic [11:0] RANGE_RST = 12'h000;
    localparam int LIMEN_UP_LSB = 0;
    localparam int LIMEN_LO_LSB = 4;
    localparam logic [7:0] LIMEN_RST = 8'h00;
    localparam logic [15:0] LIM_RST = 16'h0000;
    localparam int ST_SHORT = 0;
    localparam int ST_OVR = 1;
    localparam int ST_UDR = 2;
    localparam int ST_UP_LSB = 4;
    localparam int ST_LO_LSB = 8;
    localparam logic [11:0] STATUS_RST = 12'h000;
    localparam logic [11:0] IRQEN_RST = 12'h000;
    localparam logic [1:0] FMT_OFFSET = 2'h0;
    localparam logic [1:0] FMT_SIGNMAG = 2'h1;
    localparam logic [1:0] FMT_TWOS = 2'h2;
    localparam logic [15:0] SIGN_BIT = 16'h8000;

    typedef logic signed [16:0] alic_val_t;

    // ----------------------------------------------------------------
    // Per-range tables, hundredths, indexed by range code 0..7
    // ----------------------------------------------------------------
    // Codes: +-10V, +-5V, +-20mA, 0-10V, 0-5V, 1-5V, 0-20mA, 4-20mA
    localparam alic_val_t EXT_LO [8] = '{-17'sh41A, -17'sh20D, -17'sh834,
        17'sh000, 17'sh000, 17'sh04B, 17'sh000, 17'sh12C};
    localparam alic_val_t EXT_HI [8] = '{17'sh41A, 17'sh20D, 17'sh834,
        17'sh41A, 17'sh20D, 17'sh20D, 17'sh834, 17'sh834};
    localparam alic_val_t GAP [8] = '{17'sh005, 17'sh003, 17'sh00A,
        17'sh005, 17'sh003, 17'sh003, 17'sh00A, 17'sh00A};
    // Nominal span edge plus half a percent of span
    localparam alic_val_t OVR_HI [8] = '{17'sh3F2, 17'sh1F9, 17'sh7E4,
        17'sh3ED, 17'sh1F6, 17'sh1F6, 17'sh7DA, 17'sh7D8};
    localparam alic_val_t UDR_LO [8] = '{-17'sh3F2, -17'sh1F9, -17'sh7E4,
        -17'sh005, -17'sh002, 17'sh062, -17'sh00A, 17'sh188};

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Sign bit plus magnitude in hundredths
    function automatic alic_val_t alic_sm_decode(input logic [15:0] code);
        alic_val_t mag;
        mag = alic_val_t'({2'b00, code[14:0]});
        return code[15] ? -mag : mag;
    endfunction : alic_sm_decode

    function automatic alic_val_t alic_clamp(input alic_val_t v,
                                             input alic_val_t lo,
                                             input alic_val_t hi);
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : alic_clamp

    // Unused format code falls back to offset binary
    function automatic logic [15:0] alic_format(input logic [15:0] v,
                                                input logic [1:0] f);
        logic [15:0] mag;
        mag = v[15] ? -v : v;
        case (f)
            FMT_SIGNMAG: return {v[15], mag[14:0]};
            FMT_TWOS: return v;
            default: return v ^ SIGN_BIT;
        endcase
    endfunction : alic_format

endpackage : alic_pkg

// >>> alic_limit_chk.sv
/*
 * One channel's range and user limit comparison, purely combinational.
 * Assumes range code, limit codes and sample come from the register
 * file and the sample port of the parent.
 */
`timescale 1ns/10ps
module alic_limit_chk (
    input wire logic [2:0] rng, // Range code
    input wire logic [15:0] smp, // Sample, signed hundredths
    input wire logic [15:0] up_code, // Upper limit, sign-magnitude
    input wire logic [15:0] lo_code, // Lower limit, sign-magnitude
    output logic up_hit, // Above upper limit
    output logic lo_hit, // Below lower limit
    output logic ovr_hit, // Over range
    output logic udr_hit // Under range
);
    alic_pkg::alic_val_t v;
    alic_pkg::alic_val_t up_raw;
    alic_pkg::alic_val_t lo_raw;
    alic_pkg::alic_val_t up_lim;
    alic_pkg::alic_val_t lo_lim;

    // ----------------------------------------------------------------
    // Limit decode and band clamp
    // ----------------------------------------------------------------
    assign v = alic_pkg::alic_val_t'({smp[15], smp});
    assign up_raw = alic_pkg::alic_sm_decode(up_code);
    assign lo_raw = alic_pkg::alic_sm_decode(lo_code);
    assign up_lim = alic_pkg::alic_clamp(up_raw,
        alic_pkg::EXT_LO[rng] + alic_pkg::GAP[rng], alic_pkg::EXT_HI[rng]);
    assign lo_lim = alic_pkg::alic_clamp(lo_raw,
        alic_pkg::EXT_LO[rng], alic_pkg::EXT_HI[rng] - alic_pkg::GAP[rng]);

    // ----------------------------------------------------------------
    // Comparisons
    // ----------------------------------------------------------------
    // strictly above upper
    assign up_hit = v > up_lim;
    assign lo_hit = v < lo_lim;
    assign ovr_hit = v > alic_pkg::OVR_HI[rng];
    assign udr_hit = v < alic_pkg::UDR_LO[rng];

endmodule : alic_limit_chk

// >>> alic_host_model.sv
/*
 * APB master standing in for the controller that configures the unit.
 * Assumes the bench hands it one request at a time and waits for done.
 */
`timescale 1ns/10ps
module alic_host_model (
    input wire logic pclk, // Bus clock
    input wire logic presetn, // Async reset, low active
    input wire logic req, // Start one transfer
    input wire logic req_wr, // Direction of the request
    input wire logic [7:0] req_addr, // Byte address
    input wire logic [31:0] req_wdata, // Write data
    output logic psel, // APB select
    output logic penable, // APB enable
    output logic pwrite, // APB direction
    output logic [7:0] paddr, // APB address
    output logic [31:0] pwdata, // APB write data
    input wire logic [31:0] prdata, // APB read data
    input wire logic pready, // APB ready
    input wire logic pslverr, // APB error
    output logic done, // One-cycle end of transfer
    output logic [31:0] rdata, // Captured read data
    output logic err // Captured error flag
);
    logic [1:0] ph;

    // ----------------------------------------------------------------
    // Setup, access, wait for ready
    // ----------------------------------------------------------------
    // Released address and write data are inverted so stale values cannot look valid
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            psel <= 1'b0;
            penable <= 1'b0;
            pwrite <= 1'b0;
            paddr <= 8'h00;
            pwdata <= 32'h0;
            done <= 1'b0;
            rdata <= 32'h0;
            err <= 1'b0;
            ph <= 2'h0;
        end else begin
            done <= 1'b0;
            if (ph == 2'h0 && req) begin
                psel <= 1'b1;
                pwrite <= req_wr;
                paddr <= req_addr;
                pwdata <= req_wdata;
                ph <= 2'h1;
            end else if (ph == 2'h1) begin
                penable <= 1'b1;
                ph <= 2'h2;
            end else if (ph == 2'h2 && pready) begin
                psel <= 1'b0;
                penable <= 1'b0;
                paddr <= ~paddr;
                pwdata <= ~pwdata;
                rdata <= prdata;
                err <= pslverr;
                done <= 1'b1;
                ph <= 2'h0;
            end
        end
    end
endmodule : alic_host_model

// >>> analog_input_limit_check_tb.sv
/*
 * Self-checking bench for the limit checker, with an integer model.
 * Assumes the host model as APB master and samples driven directly.
 */
`timescale 1ns/10ps
module analog_input_limit_check_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic req = 1'b0;
    logic req_wr = 1'b0;
    logic [7:0] req_addr = 8'h00;
    logic [31:0] req_wdata = 32'h0;
    logic sample_valid = 1'b0;
    logic [63:0] sample_data = 64'h0;
    logic supply_short = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, irq, done, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdata, rd;
    int fails = 0;
    int total_checks = 0;
    int seed = 32'h48FB80FA;
    int m_ctrl = 7;
    int m_irqen = 0;
    int m_limen = 0;
    int m_rng [4];
    int m_up [4];
    int m_lo [4];
    int m_smp [4];

    // ----------------------------------------------------------------
    // Clock, design and host
    // ----------------------------------------------------------------
    initial forever #25 pclk = ~pclk;

    alic_top uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sample_valid(sample_valid),
        .sample_data(sample_data), .supply_short(supply_short), .irq(irq));

    alic_host_model host (.pclk(pclk), .presetn(presetn), .req(req),
        .req_wr(req_wr), .req_addr(req_addr), .req_wdata(req_wdata),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .done(done), .rdata(rdata), .err(err));

    // ----------------------------------------------------------------
    // Reporting and compares
    // ----------------------------------------------------------------
    task automatic close_out;
        $display("Checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out

    task automatic cmp_reg(string nm, logic [31:0] e, logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp_reg

    task automatic cmp_bit(string nm, logic e, logic g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %b seen %b", nm, e, g);
        end
    endtask : cmp_bit

    // One transfer through the host; bounded wait on done
    task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
        int n;
        @(posedge pclk);
        req <= 1'b1;
        req_wr <= wr;
        req_addr <= a;
        req_wdata <= d;
        @(posedge pclk);
        req <= 1'b0;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (done !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            close_out();
        end
        rd = rdata;
    endtask : bus

    // ----------------------------------------------------------------
    // Reference model
    // ----------------------------------------------------------------
    // limit code forming
    function automatic logic [15:0] enc(int v);
        return v < 0 ? (16'h8000 | 16'(-v)) : 16'(v);
    endfunction : enc

    function automatic int clampi(int v, int lo, int hi);
        return v < lo ? lo : (v > hi ? hi : v);
    endfunction : clampi

    function automatic logic [15:0] fmt(int v, int f);
        logic [15:0] x;
        x = 16'(v);
        case (f & 3)
            1: return {x[15], 15'(x[15] ? -x : x)};
            2: return x;
            default: return x ^ 16'h8000;
        endcase
    endfunction : fmt

    // Limits are clamped into the band before the strict compare
    function automatic logic [11:0] exp_st();
        logic [11:0] s;
        int r, ul, ll;
        s = 12'h000;
        for (int c = 0; c < 4; c++) begin
            r = m_rng[c];
            ul = clampi(m_up[c], alic_pkg::EXT_LO[r] + alic_pkg::GAP[r],
                alic_pkg::EXT_HI[r]);
            ll = clampi(m_lo[c], alic_pkg::EXT_LO[r],
                alic_pkg::EXT_HI[r] - alic_pkg::GAP[r]);
            if (m_ctrl[1] && m_smp[c] > alic_pkg::OVR_HI[r]) s[1] = 1'b1;
            if (m_ctrl[2] && m_smp[c] < alic_pkg::UDR_LO[r]) s[2] = 1'b1;
            if (m_limen[c] && m_smp[c] > ul) s[4 + c] = 1'b1;
            if (m_limen[4 + c] && m_smp[c] < ll) s[8 + c] = 1'b1;
        end
        return s;
    endfunction : exp_st

    function automatic int rnd();
        return (($random(seed) & 32'h7FFF) % 4601) - 2300;
    endfunction : rnd

    // ----------------------------------------------------------------
    // Stimulus tasks
    // ----------------------------------------------------------------
    task automatic apply();
        @(posedge pclk);
        sample_valid <= 1'b1;
        sample_data <= {16'(m_smp[3]), 16'(m_smp[2]), 16'(m_smp[1]),
            16'(m_smp[0])};
        @(posedge pclk);
        sample_valid <= 1'b0;
        sample_data <= ~sample_data;
    endtask : apply

    // Status and interrupt level, then clear every sticky bit
    task automatic chk_status(logic [11:0] e);
        bus(1'b0, alic_pkg::OFF_STATUS, 32'h0);
        cmp_reg("status", {20'h0, e}, rd);
        cmp_bit("irq", |(e & 12'(m_irqen)), irq);
        bus(1'b1, alic_pkg::OFF_CLEAR, 32'hFFF);
    endtask : chk_status

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values; the clear register is write-only and skipped
        for (int i = 0; i < 20; i++) begin
            if (i != 4) begin
                bus(1'b0, 8'(i * 4), 32'h0);
                cmp_reg("reset", i == 0 ? 32'h7 :
                    (i > 15 ? 32'h8000 : 0), rd);
                cmp_bit("slverr", i == 6 || i == 7, err);
            end
        end
        $display("Test reset values done");
        m_smp = '{1500, -1500, 5, -5};
        apply();
        chk_status(exp_st());
        $display("Test defaults done");
        // Short enabled, disabled, masked, then frozen by ce
        for (int k = 0; k < 4; k++) begin
            m_ctrl = k == 1 ? 6 : 7;
            m_irqen = k == 2 ? 0 : 1;
            bus(1'b1, alic_pkg::OFF_CTRL, 32'(m_ctrl));
            bus(1'b1, alic_pkg::OFF_IRQEN, 32'(m_irqen));
            @(posedge pclk) supply_short <= 1'b1;
            ce <= k != 3;
            @(posedge pclk) supply_short <= 1'b0;
            ce <= 1'b1;
            chk_status(12'(m_ctrl & (k != 3)));
        end
        $display("Test supply short done");
        for (int it = 0; it < 40; it++) begin
            m_ctrl = $random(seed) & 32'h37;
            m_irqen = $random(seed) & 32'hFF7;
            m_limen = $random(seed) & 32'hFF;
            bus(1'b1, alic_pkg::OFF_CTRL, 32'(m_ctrl));
            bus(1'b1, alic_pkg::OFF_IRQEN, 32'(m_irqen));
            bus(1'b1, alic_pkg::OFF_LIMEN, 32'(m_limen));
            for (int c = 0; c < 4; c++) begin
                m_rng[c] = $random(seed) & 7;
                m_up[c] = rnd();
                m_lo[c] = rnd();
                m_smp[c] = rnd();
            end
            bus(1'b1, alic_pkg::OFF_RANGE, 32'(m_rng[0] | m_rng[1] << 3 |
                m_rng[2] << 6 | m_rng[3] << 9));
            // limits rewritten after each range change
            for (int c = 0; c < 4; c++) begin
                bus(1'b1, 8'(alic_pkg::OFF_UPLIM + 4 * c), 32'(enc(m_up[c])));
                bus(1'b1, 8'(alic_pkg::OFF_LOLIM + 4 * c), 32'(enc(m_lo[c])));
            end
            apply();
            chk_status(exp_st());
            bus(1'b0, 8'(alic_pkg::OFF_DATA + 4 * (it % 4)), 32'h0);
            cmp_reg("data", 32'(fmt(m_smp[it % 4], m_ctrl >> 4)), rd);
        end
        $display("Test random limits done");
        close_out();
    end
endmodule : analog_input_limit_check_tb
